// file: rtl/scan_channel_ctrl.sv
// External scanner channel control: selects the active channel of the scanned input.
// Assumes configuration ports are driven from the same clock; select inputs come from pins.
//
// What this block does
// - Sixteen channels share the first input and its one sensor-type setting.
// - Each of sixteen channels keeps its own curve selection.
// - Unread channels keep showing their last valid reading.
// - Four modes: manual, auto, slave, off; off is the default.
// - Off mode disables sequencing and channel reporting.
// - Manual mode activates the chosen channel; default is the first channel.
// - Report outputs driven in manual or auto only when configured for scanner.
// - Channel n reported as binary n minus 1, bit 3 most significant.
// - Auto mode steps through channels, dwelling the set interval on each.
// - Dwell interval in whole seconds, 2 to 200, default 2.
// - Auto sequence skips channels whose enable is off.
// - Auto mode reports the active channel with the manual encoding.
// - Slave mode makes active the channel coded on the four inputs.
// - Select inputs are sampled without any dedicated configuration.
// - Enable and curve are per channel; other settings are global.
// - Enables reset on; active channel resets to channel 1.
`timescale 1ns/10ps
`include "scan_defines.svh"

module scan_channel_ctrl
	import scan_pkg::*;
#(
	// Clock cycles per dwell second; a bench may shorten it
	parameter int TICK_CYCLES = `SCAN_TICK_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire scan_mode_t  scan_mode,
	input  wire logic [3:0]  manual_channel,
	input  wire logic [7:0]  scan_interval,
	input  wire logic        report_scanner_mode,
	input  wire logic [3:0]  setup_channel_sel,
	input  wire logic        setup_write,
	input  wire logic        setup_enable,
	input  wire logic [3:0]  setup_curve,
	input  wire logic [3:0]  curve_read_sel,
	input  wire logic        chan_select_in_bit0,
	input  wire logic        chan_select_in_bit1,
	input  wire logic        chan_select_in_bit2,
	input  wire logic        chan_select_in_bit3,
	input  wire logic        reading_valid,
	input  wire logic [15:0] reading_value,
	input  wire logic [3:0]  held_read_sel,
	output logic [3:0]       active_channel,
	output logic             scan_active,
	output logic [15:0]      channel_enable,
	output logic [3:0]       curve_read,
	output logic [15:0]      held_reading,
	output logic             chan_report_bit0,
	output logic             chan_report_bit1,
	output logic             chan_report_bit2,
	output logic             chan_report_bit3,
	output logic             chan_report_en
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] sel_meta_r;
	logic [3:0] sel_sync_r;
	logic [3:0] pin_code;

	assign pin_code = {chan_select_in_bit3, chan_select_in_bit2, chan_select_in_bit1, chan_select_in_bit0};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_meta_r <= 4'h0;
			sel_sync_r <= 4'h0;
		end else begin
			// Always sampled, no configuration needed
			sel_meta_r <= pin_code;
			sel_sync_r <= sel_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Per-channel settings
	// ------------------------------------------------------------
	logic [15:0] enable_r;
	logic [3:0]  curve_r [0:15];

	// The selector is a plain level, so a write lands on the channel it names in that cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= `SCAN_ENABLE_RST;
		end else if (setup_write) begin
			enable_r[setup_channel_sel] <= setup_enable;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `SCAN_NUM_CHANNELS; i++)
				curve_r[i] <= `SCAN_CURVE_RST;
		end else if (setup_write) begin
			curve_r[setup_channel_sel] <= setup_curve;
		end
	end

	assign channel_enable = enable_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			curve_read <= `SCAN_CURVE_RST;
		end else begin
			curve_read <= curve_r[curve_read_sel];
		end
	end

	// ------------------------------------------------------------
	// Dwell timer
	// ------------------------------------------------------------
	localparam logic [25:0] TICK_MAX = 26'(TICK_CYCLES - 1);

	logic [25:0] tick_cnt_r;
	logic [7:0]  sec_cnt_r;
	logic        tick;
	logic        advance;
	logic        mode_changed;
	logic        timer_clear;
	scan_mode_t  mode_q_r;
	logic [7:0]  interval_lim;

	// Clamp out-of-range settings instead of stalling the sequence
	assign interval_lim = (scan_interval < `SCAN_INTERVAL_MIN) ? `SCAN_INTERVAL_MIN :
	                      (scan_interval > `SCAN_INTERVAL_MAX) ? `SCAN_INTERVAL_MAX : scan_interval;
	assign mode_changed = (mode_q_r != scan_mode);
	assign tick         = (tick_cnt_r == TICK_MAX);
	// Compare with >= so a shortened interval ends the current dwell at the next tick
	assign advance      = (scan_mode == MODE_AUTO) && !mode_changed && tick &&
	                      (sec_cnt_r + 8'h01 >= interval_lim);
	// Any mode change or advance restarts the dwell from zero
	assign timer_clear  = mode_changed || advance || (scan_mode != MODE_AUTO);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q_r <= MODE_OFF;
		end else begin
			mode_q_r <= scan_mode;
		end
	end

	// Sub-second counter: one tick every TICK_CYCLES clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 26'h0;
		end else if (timer_clear || tick) begin
			tick_cnt_r <= 26'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 26'h1;
		end
	end

	// Whole seconds spent on the current channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_r <= 8'h00;
		end else if (timer_clear) begin
			sec_cnt_r <= 8'h00;
		end else if (tick) begin
			sec_cnt_r <= sec_cnt_r + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Active channel selection
	// ------------------------------------------------------------
	logic [3:0] next_enabled;
	logic       entry_skip;

	// Next enabled channel after the current one; stays put if none is enabled
	always_comb begin
		logic [3:0] cand;
		logic       found;
		cand         = 4'h0;
		found        = 1'b0;
		next_enabled = active_channel;
		for (int k = 1; k <= `SCAN_NUM_CHANNELS; k++) begin
			cand = active_channel + k[3:0];
			if (!found && enable_r[cand]) begin
				next_enabled = cand;
				found        = 1'b1;
			end
		end
	end

	// Entering auto on a disabled channel would dwell on it once; step off it at once
	assign entry_skip = (scan_mode == MODE_AUTO) && mode_changed && !enable_r[active_channel];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_channel <= `SCAN_FIRST_CHANNEL;
		end else begin
			case (scan_mode)
				MODE_MANUAL: begin
					active_channel <= manual_channel;
				end
				MODE_AUTO: begin
					if (advance || entry_skip) begin
						active_channel <= next_enabled;
					end
				end
				MODE_SLAVE: begin
					active_channel <= sel_sync_r;
				end
				MODE_OFF: begin
					active_channel <= active_channel;
				end
				default: begin
					active_channel <= active_channel;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status and channel report outputs
	// ------------------------------------------------------------
	logic report_live;

	// Reports only in manual or auto, and only with outputs serving the scanner
	assign report_live = report_scanner_mode && (scan_mode == MODE_MANUAL || scan_mode == MODE_AUTO);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_active <= 1'b0;
		end else begin
			scan_active <= (scan_mode != MODE_OFF);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_report_en <= 1'b0;
		end else begin
			chan_report_en <= report_live;
		end
	end

	// Channel codes are n-1 everywhere, so channel 12 is 1011
	// Idle low: a switch that ignores the enable falls back to channel 1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_report_bit0 <= 1'b0;
			chan_report_bit1 <= 1'b0;
			chan_report_bit2 <= 1'b0;
			chan_report_bit3 <= 1'b0;
		end else if (report_live) begin
			chan_report_bit0 <= active_channel[0];
			chan_report_bit1 <= active_channel[1];
			chan_report_bit2 <= active_channel[2];
			chan_report_bit3 <= active_channel[3];
		end else begin
			chan_report_bit0 <= 1'b0;
			chan_report_bit1 <= 1'b0;
			chan_report_bit2 <= 1'b0;
			chan_report_bit3 <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Last valid reading per channel
	// ------------------------------------------------------------
	logic [15:0] held_r [0:15];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int j = 0; j < `SCAN_NUM_CHANNELS; j++)
				held_r[j] <= `SCAN_HELD_RST;
		end else if (reading_valid && scan_mode != MODE_OFF) begin
			held_r[active_channel] <= reading_value;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_reading <= `SCAN_HELD_RST;
		end else begin
			held_reading <= held_r[held_read_sel];
		end
	end

endmodule : scan_channel_ctrl

// file: rtl/scan_defines.svh
// Timing counts, reset values and encodings for the external scanner channel control.
// Assumes a single 50 MHz clock.
`ifndef SCAN_DEFINES_SVH
`define SCAN_DEFINES_SVH

`define SCAN_CLK_HZ          50000000
`define SCAN_TICK_CYCLES     (`SCAN_CLK_HZ)
`define SCAN_NUM_CHANNELS    16
`define SCAN_INTERVAL_MIN    8'h02
`define SCAN_INTERVAL_MAX    8'hC8
`define SCAN_INTERVAL_RST    8'h02
`define SCAN_FIRST_CHANNEL   4'h0
`define SCAN_ENABLE_RST      16'hFFFF
`define SCAN_CURVE_RST       4'h0
`define SCAN_HELD_RST        16'h0000

`endif

// file: rtl/scan_pkg.sv
// Types shared by the external scanner channel control.
// Assumes nothing of its surroundings.
package scan_pkg;

	// Gray-coded along off -> manual -> auto -> slave
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_AUTO   = 2'b11,
		MODE_SLAVE  = 2'b10
	} scan_mode_t;

endpackage : scan_pkg

// file: test/scan_channel_ctrl_sva.sv
// Port checker for the scanner channel control.
// Assumes one clock domain; bound to the design below.
`timescale 1ns/10ps
module scan_sva
	import scan_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire scan_mode_t scan_mode,
	input wire logic [3:0] manual_channel,
	input wire logic       report_scanner_mode,
	input wire logic       chan_select_in_bit0,
	input wire logic       chan_select_in_bit1,
	input wire logic       chan_select_in_bit2,
	input wire logic       chan_select_in_bit3,
	input wire logic [3:0] active_channel,
	input wire logic       scan_active,
	input wire logic       chan_report_bit0,
	input wire logic       chan_report_bit1,
	input wire logic       chan_report_bit2,
	input wire logic       chan_report_bit3,
	input wire logic       chan_report_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [3:0] rep = {chan_report_bit3, chan_report_bit2, chan_report_bit1, chan_report_bit0};
	wire [3:0] pins = {chan_select_in_bit3, chan_select_in_bit2, chan_select_in_bit1, chan_select_in_bit0};
	AST_OFF_DARK: assert property (scan_mode == MODE_OFF |=> !chan_report_en && rep == 4'h0)
		else $error("report live in off mode");
	AST_OFF_HOLD: assert property (scan_mode == MODE_OFF |=> $stable(active_channel))
		else $error("channel moved in off mode");
	AST_MAN_SEL: assert property (scan_mode == MODE_MANUAL |=> active_channel == $past(manual_channel))
		else $error("manual channel not taken");
	AST_REP_ON: assert property (report_scanner_mode && scan_mode inside {MODE_MANUAL, MODE_AUTO} |=> chan_report_en)
		else $error("report not enabled");
	AST_REP_GATE: assert property (!report_scanner_mode |=> !chan_report_en)
		else $error("report enabled while not configured");
	AST_REP_CODE: assert property (chan_report_en |-> rep == $past(active_channel))
		else $error("report code differs from channel");
	// Sync stages clear in reset, so wait until they hold real pin history
	AST_SLV_SEL: assert property (scan_mode == MODE_SLAVE && $past(rst_n, 4) |=> active_channel == $past(pins, 3))
		else $error("slave channel not followed");
	AST_ACT: assert property ($past(rst_n) |-> scan_active == ($past(scan_mode) != MODE_OFF))
		else $error("scan active flag wrong");
	cover property (scan_mode == MODE_SLAVE ##3 1'b1);
	cover property (chan_report_en && rep == 4'hB);
	cover property (scan_mode == MODE_AUTO && chan_report_en);
endmodule : scan_sva

bind scan_channel_ctrl scan_sva chk (.*);

// file: test/scan_partner.sv
// External scanner model facing the channel lines.
// Assumes the controller clock; drives select pins, follows reports.
`timescale 1ns/10ps
module scan_partner (
	input  wire logic       clk,
	input  wire logic [3:0] slave_code,
	input  wire logic [3:0] rep,
	input  wire logic       chan_report_en,
	output logic            chan_select_in_bit0 = 1'b0,
	output logic            chan_select_in_bit1 = 1'b0,
	output logic            chan_select_in_bit2 = 1'b0,
	output logic            chan_select_in_bit3 = 1'b0,
	output logic [3:0]      seen_code = 4'h0
);
	// One sensor type only on this switch
	// Pins lag the request a cycle, as a real switch settles late
	always_ff @(posedge clk)
		{chan_select_in_bit3, chan_select_in_bit2, chan_select_in_bit1, chan_select_in_bit0} <= slave_code;
	always_ff @(posedge clk)
		if (chan_report_en) seen_code <= rep;
endmodule : scan_partner

// file: test/tb.sv
// Self-checking bench for the scanner channel control.
// Assumes define file, package, design, model and checker compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t %h %h", $time, a, b); end end
module tb
	import scan_pkg::*;
;
	logic        clk = 0, rst_n = 0, report_scanner_mode = 0, setup_write = 0, setup_enable = 0;
	logic        reading_valid = 0, scan_active, chan_report_en;
	logic        chan_select_in_bit0, chan_select_in_bit1, chan_select_in_bit2, chan_select_in_bit3;
	logic        chan_report_bit0, chan_report_bit1, chan_report_bit2, chan_report_bit3;
	scan_mode_t  scan_mode = MODE_OFF;
	logic [3:0]  manual_channel = 4'h0, setup_channel_sel = 4'h0, setup_curve = 4'h0, slave_code = 4'h0;
	logic [3:0]  curve_read_sel = 4'h0, held_read_sel = 4'h0, active_channel, curve_read, seen_code;
	logic [7:0]  scan_interval = 8'h02;
	logic [15:0] reading_value = 16'h0000, channel_enable, held_reading;
	int          err_total = 0, n_tests = 0;
	wire  [3:0]  rep = {chan_report_bit3, chan_report_bit2, chan_report_bit1, chan_report_bit0};
	// Ten-clock seconds keep even the longest dwell inside the run
	scan_channel_ctrl #(.TICK_CYCLES(10)) uut (.*);
	scan_partner scanner (.*);
	initial forever #10 clk = ~clk;
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task t_manual();
		scan_mode = MODE_MANUAL;
		report_scanner_mode = 1;
		for (int i = 0; i < 16; i++) begin
			manual_channel = i[3:0];
			step(2);
			`CHK(active_channel, i[3:0])
			`CHK(rep, i[3:0])
		end
		step(1);
		`CHK(seen_code, 4'hF)
		report_scanner_mode = 0;
		step(1);
		`CHK({chan_report_en, rep}, 5'h00)
	endtask : t_manual
	task t_off();
		scan_mode = MODE_OFF;
		report_scanner_mode = 1;
		manual_channel = 4'h7;
		step(3);
		`CHK({scan_active, chan_report_en, rep, active_channel}, 10'h00F)
	endtask : t_off
	task t_slave(input logic [3:0] c);
		scan_mode = MODE_SLAVE;
		slave_code = c;
		step(5);
		`CHK({chan_report_en, active_channel}, {1'b0, c})
	endtask : t_slave
	task t_setup();
		setup_channel_sel = 4'h3;
		setup_curve = 4'h5;
		setup_write = 1;
		step(1);
		setup_channel_sel = 4'hF;
		setup_curve = 4'hA;
		step(1);
		setup_write = 0;
		curve_read_sel = 4'h3;
		step(1);
		`CHK(curve_read, 4'h5)
		curve_read_sel = 4'hF;
		step(1);
		`CHK({channel_enable, curve_read}, 20'h7FF7A)
	endtask : t_setup
	task t_held();
		scan_mode = MODE_MANUAL;
		manual_channel = 4'h2;
		step(1);
		reading_valid = 1;
		reading_value = 16'h1234;
		step(1);
		reading_valid = 0;
		manual_channel = 4'h4;
		step(1);
		reading_valid = 1;
		reading_value = 16'h5678;
		step(1);
		reading_valid = 0;
		held_read_sel = 4'h2;
		step(1);
		`CHK(held_reading, 16'h1234)
		held_read_sel = 4'h4;
		step(1);
		`CHK(held_reading, 16'h5678)
		scan_mode = MODE_OFF;
		reading_valid = 1;
		reading_value = 16'hBEEF;
		step(1);
		reading_valid = 0;
		step(1);
		`CHK(held_reading, 16'h5678)
	endtask : t_held
	task t_auto();
		scan_interval = 8'h00;
		scan_mode = MODE_AUTO;
		step(20);
		`CHK(active_channel, 4'h4)
		step(1);
		`CHK(active_channel, 4'h5)
		step(1);
		`CHK({chan_report_en, rep}, 5'h15)
		step(199);
		`CHK(active_channel, 4'h0)
		step(60);
		`CHK(active_channel, 4'h4)
		scan_interval = 8'hFF;
		step(1999);
		`CHK(active_channel, 4'h4)
		step(1);
		`CHK(active_channel, 4'h5)
	endtask : t_auto
	task wrap_up();
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		step(12);
		rst_n = 1;
		`CHK({channel_enable, active_channel, scan_active}, 21'h1FFFE0)
		t_manual();
		t_off();
		t_slave(4'h5);
		t_slave(4'hB);
		t_slave(4'hF);
		t_setup();
		t_held();
		t_auto();
		wrap_up();
	end
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
endmodule : tb
